/* File: design/asr_pkg.sv */
// Package: constants, register map and field layout of the serial receiver
package asr_pkg;

  // ==========================================================
  // Register map (plain port, word index)
  // ==========================================================
  localparam logic [3:0] ADDR_MODE = 4'h0; // Serial mode register
  localparam logic [3:0] ADDR_BAUD = 4'h1; // Bit-time divisor k
  localparam logic [3:0] ADDR_RXBUF = 4'h2; // Receive buffer
  localparam logic [3:0] ADDR_STAT = 4'h3; // Receive error status

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] MODE_RST = 8'h00; // Receiver off
  localparam logic [4:0] BAUD_RST = 5'h10; // k = 16
  localparam logic [7:0] RXBUF_RST = 8'h00; // Empty buffer
  localparam logic [2:0] STAT_RST = 3'h0; // No errors

  // ==========================================================
  // Error status bit positions (values 04H, 02H, 01H)
  // ==========================================================
  localparam int STAT_PAR_BIT = 2; // Parity error
  localparam int STAT_FRM_BIT = 1; // Framing error
  localparam int STAT_OVR_BIT = 0; // Overrun error

  // ==========================================================
  // Counter widths and character sizes
  // ==========================================================
  localparam int BAUD_W = 5; // 5-bit baud counter
  localparam int PRESC_W = 3; // Serial clock prescaler
  localparam logic [2:0] LAST_BIT_7 = 3'h6; // Index of 7th bit
  localparam logic [2:0] LAST_BIT_8 = 3'h7; // Index of 8th bit

  // ==========================================================
  // Types
  // ==========================================================
  // Parity modes
  typedef enum logic [1:0]
  {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD = 2'h2,
    PAR_EVEN = 2'h3
  } asr_par_e;

  // Serial mode register layout, bit 7 down to bit 0
  typedef struct packed
  {
    logic [1:0] clk_sel; // Serial clock divide 1/2/4/8
    logic rx_en; // Bit 5: receive enable
    asr_par_e parity; // Parity mode
    logic len8; // 1: 8-bit characters, 0: 7-bit
    logic stop2; // Two stop bits configured
    logic error_completion_irq_select; // Bit 0: completion irq on error frames
  } asr_mode_s;

endpackage : asr_pkg

/* File: design/asr_bit_timer.sv */
// Bit timer: 5-bit baud counter producing a sampling strobe
`timescale 1ns/1ps
`default_nettype none

module asr_bit_timer #(
  parameter int W = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic [W-1:0] limit_i,
  output logic strobe_o
);

  // ==========================================================
  // Counter
  // ==========================================================
  logic [W-1:0] cnt_q; // Serial clock ticks seen in this period

  // Count serial clock ticks; restart reinitialises the count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else if (restart_i)
    begin
      cnt_q <= '0;
    end
    else if (tick_i)
    begin
      // Wrap at the limit so strobes repeat every limit ticks
      if (cnt_q == limit_i - W'(1))
      begin
        cnt_q <= '0;
      end
      else
      begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  // Registered one-cycle strobe at end of each period
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strobe_o <= 1'b0;
    end
    else
    begin
      strobe_o <= !restart_i && tick_i && (cnt_q == limit_i - W'(1));
    end
  end

endmodule : asr_bit_timer

`default_nettype wire

/* File: design/asr_receiver.sv */
// Top: asynchronous serial receiver with register port
// Functional notes
// - Receive only while enable bit set
// - Sample with serial clock chosen by mode
// - Low input starts half-bit timer
// - Still low at half-bit: start, else ignore
// - Frame ends after first stop bit
// - Completed frame to buffer, completion irq
// - Error frames buffered; completion irq if selected
// - Clearing enable aborts silently
// - Any error flag raises error irq
// - Error irq precedes completion irq
// - Buffer read or next frame clears status
// - Parity mismatch reports 04H
// - Low stop bit reports 02H
// - Unread buffer overwritten reports 01H
// - Even/odd parity count check
// - Zero parity never checked
// - 7-bit characters read MSB zero
// - Frame format taken from mode fields
`timescale 1ns/1ps
`default_nettype none

module asr_receiver (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic RXD_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic CMP_IRQ_O,
  output logic ERR_IRQ_O
);

  // ==========================================================
  // Declarations
  // ==========================================================
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} asr_st_e;

  asr_pkg::asr_mode_s mode_q; // Serial mode register
  logic [4:0] baud_q; // Divisor k
  logic [7:0] rxbuf_q; // Receive buffer
  logic [2:0] stat_q; // Error status flags
  logic full_q; // Buffer holds unread data
  logic rx_s1_q; // Synchroniser stage 1
  logic rx_s2_q; // Synchronised receive input
  asr_st_e st_q; // Receiver state
  logic [7:0] shf_q; // Receive shift register
  logic [2:0] bit_q; // Data bit index
  logic par_err_q; // Parity check result
  logic cmp_pend_q; // Completion irq waits one cycle
  logic [asr_pkg::PRESC_W-1:0] presc_q; // Prescaler count
  logic tick; // Serial clock enable
  logic [asr_pkg::PRESC_W-1:0] presc_mask; // Prescaler terminal mask
  logic restart; // Reinit bit timer
  logic [4:0] limit; // Half or full bit period
  logic strobe; // Sampling strobe
  logic done; // Frame complete this cycle
  logic frm_err; // Stop bit sampled low
  logic any_err; // Frame has an error
  logic buf_rd; // Software reads buffer
  logic [2:0] last_bit; // Last data bit index
  logic par_bit_err; // Parity check of sampled bit

  // ==========================================================
  // Input synchroniser
  // ==========================================================
  // Two flops; only the second is looked at
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= RXD_I;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ==========================================================
  // Serial clock prescaler
  // ==========================================================
  // Mask picks divide by 1, 2, 4 or 8
  always_comb
  begin
    case (mode_q.clk_sel)
      2'h0: presc_mask = 3'h0;
      2'h1: presc_mask = 3'h1;
      2'h2: presc_mask = 3'h3;
      default: presc_mask = 3'h7;
    endcase
  end

  assign tick = (presc_q & presc_mask) == presc_mask;

  // Free-running prescaler count
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      presc_q <= '0;
    end
    else
    begin
      presc_q <= presc_q + 3'h1;
    end
  end

  // ==========================================================
  // Bit timer
  // ==========================================================
  // Half period while qualifying the start bit, full otherwise
  assign limit = (st_q == S_START) ? {1'b0, baud_q[4:1]} : baud_q;
  assign restart = (st_q == S_IDLE) || (st_q == S_START && strobe);

  asr_bit_timer #(.W(asr_pkg::BAUD_W)) u_timer (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .tick_i(tick),
    .restart_i(restart),
    .limit_i(limit),
    .strobe_o(strobe)
  );

  // ==========================================================
  // Frame decode helpers
  // ==========================================================
  assign last_bit = mode_q.len8 ? asr_pkg::LAST_BIT_8 : asr_pkg::LAST_BIT_7;
  assign done = (st_q == S_STOP) && strobe && mode_q.rx_en;
  assign frm_err = !rx_s2_q;
  assign any_err = par_err_q || frm_err || full_q;
  assign buf_rd = RD_I && (ADDR_I == asr_pkg::ADDR_RXBUF);

  // Odd count of ones is an error for even parity and vice versa
  always_comb
  begin
    case (mode_q.parity)
      asr_pkg::PAR_EVEN: par_bit_err = ^{shf_q, rx_s2_q};
      asr_pkg::PAR_ODD: par_bit_err = ~^{shf_q, rx_s2_q};
      default: par_bit_err = 1'b0;
    endcase
  end

  // ==========================================================
  // Receive state machine
  // ==========================================================
  // Clearing enable drops straight back to idle, nothing stored
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      st_q <= S_IDLE;
      bit_q <= '0;
      shf_q <= '0;
      par_err_q <= 1'b0;
    end
    else if (!mode_q.rx_en)
    begin
      st_q <= S_IDLE;
    end
    else
    begin
      case (st_q)
        // Wait for line low
        S_IDLE:
        begin
          if (!rx_s2_q)
          begin
            st_q <= S_START;
          end
        end
        // Requalify at half bit; a glitch is dropped
        S_START:
        begin
          if (strobe)
          begin
            st_q <= rx_s2_q ? S_IDLE : S_DATA;
            bit_q <= '0;
            shf_q <= '0;
            par_err_q <= 1'b0;
          end
        end
        // LSB first, shifted in from the top
        S_DATA:
        begin
          if (strobe)
          begin
            shf_q <= {rx_s2_q, shf_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == last_bit)
            begin
              // Format read from mode fields per frame
              if (mode_q.parity == asr_pkg::PAR_NONE)
              begin
                st_q <= S_STOP;
              end
              else
              begin
                st_q <= S_PAR;
              end
            end
          end
        end
        // Parity bit received even in zero-parity mode
        S_PAR:
        begin
          if (strobe)
          begin
            par_err_q <= par_bit_err;
            st_q <= S_STOP;
          end
        end
        // Only the first stop bit is sampled
        S_STOP:
        begin
          if (strobe)
          begin
            st_q <= S_IDLE;
          end
        end
        default:
        begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Receive buffer and status
  // ==========================================================
  // 7-bit data sits right-aligned with bit 7 forced low
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rxbuf_q <= asr_pkg::RXBUF_RST;
    end
    else if (done)
    begin
      rxbuf_q <= mode_q.len8 ? shf_q : {1'b0, shf_q[7:1]};
    end
  end

  // Unread flag; a new frame wins over a same-cycle read
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      full_q <= 1'b0;
    end
    else if (done)
    begin
      full_q <= 1'b1;
    end
    else if (buf_rd)
    begin
      full_q <= 1'b0;
    end
  end

  // Status rewritten by each frame, cleared by buffer read
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      stat_q <= asr_pkg::STAT_RST;
    end
    else if (done)
    begin
      stat_q[asr_pkg::STAT_PAR_BIT] <= par_err_q;
      stat_q[asr_pkg::STAT_FRM_BIT] <= frm_err;
      stat_q[asr_pkg::STAT_OVR_BIT] <= full_q;
    end
    else if (buf_rd)
    begin
      stat_q <= '0;
    end
  end

  // ==========================================================
  // Interrupt pulses
  // ==========================================================
  // Error frames: error pulse first, completion one cycle later only if error_completion_irq_select is set
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ERR_IRQ_O <= 1'b0;
      CMP_IRQ_O <= 1'b0;
      cmp_pend_q <= 1'b0;
    end
    else
    begin
      ERR_IRQ_O <= done && any_err;
      cmp_pend_q <= done && any_err && mode_q.error_completion_irq_select;
      CMP_IRQ_O <= (done && !any_err) || cmp_pend_q;
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  // Software writes of mode and divisor
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      mode_q <= asr_pkg::MODE_RST;
      baud_q <= asr_pkg::BAUD_RST;
    end
    else if (WR_I)
    begin
      if (ADDR_I == asr_pkg::ADDR_MODE)
      begin
        mode_q <= WDATA_I;
      end
      if (ADDR_I == asr_pkg::ADDR_BAUD)
      begin
        baud_q <= WDATA_I[4:0];
      end
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      RDATA_O <= 8'h00;
    end
    else if (RD_I)
    begin
      case (ADDR_I)
        asr_pkg::ADDR_MODE: RDATA_O <= mode_q;
        asr_pkg::ADDR_BAUD: RDATA_O <= {3'h0, baud_q};
        asr_pkg::ADDR_RXBUF: RDATA_O <= rxbuf_q;
        asr_pkg::ADDR_STAT: RDATA_O <= {5'h00, stat_q};
        default: RDATA_O <= 8'h00; // Unmapped reads zero
      endcase
    end
    else
    begin
      RDATA_O <= 8'h00;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_sync_two_stage: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    1'b1 |-> ##2 rx_s2_q == $past(RXD_I, 2))
    else $error("receive input not synchronised in two stages");

  a_disabled_idle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    // A completion owed by a frame that ended before the clear still fires
    (!mode_q.rx_en && !cmp_pend_q)
      |=> st_q == S_IDLE && !CMP_IRQ_O && !ERR_IRQ_O)
    else $error("receiver active while disabled");

  a_abort_silent: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    // A software buffer read may still clear status during the abort
    (st_q != S_IDLE && !mode_q.rx_en && !buf_rd)
      |=> $stable(rxbuf_q) && $stable(stat_q))
    else $error("abort changed buffer or status");

  a_false_start: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (st_q == S_START && strobe && rx_s2_q && mode_q.rx_en)
      |=> st_q == S_IDLE)
    else $error("high level at half bit accepted as start");

  a_err_then_cmp: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (done && any_err) |=> ERR_IRQ_O && !CMP_IRQ_O
      ##1 CMP_IRQ_O == $past(mode_q.error_completion_irq_select, 2))
    else $error("error/completion irq order wrong");

  a_clean_cmp: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (done && !any_err) |=> CMP_IRQ_O && !ERR_IRQ_O)
    else $error("clean frame missing completion irq");

  a_status_codes: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    done |=> stat_q == {$past(par_err_q), $past(frm_err), $past(full_q)})
    else $error("status code does not match frame errors");

  a_read_clears: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (buf_rd && !done) |=> stat_q == 3'h0 && !full_q)
    else $error("buffer read did not clear status");

  a_zero_par: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (st_q == S_PAR && strobe && mode_q.parity == asr_pkg::PAR_ZERO)
      |=> !par_err_q)
    else $error("zero parity produced an error");

  a_seven_msb: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (done && !mode_q.len8) |=> !rxbuf_q[7])
    else $error("7-bit character with MSB set");

endmodule : asr_receiver

`default_nettype wire

/* File: dv/asr_tx_model.sv */
// Partner model: remote asynchronous serial transmitter on the receive line
`timescale 1ns/1ps
`default_nettype none

module asr_tx_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic short_i,
  input wire logic [7:0] data_i,
  input wire logic len8_i,
  input wire asr_pkg::asr_par_e par_i,
  input wire logic par_flip_i,
  input wire logic stop_bad_i,
  input wire logic [7:0] bit_len_i,
  output logic line_o,
  output logic busy_o
);
  // ==========================================================
  // Frame sender
  // ==========================================================
  logic bits [$]; // Frame bits, front goes out first
  logic par_b; // XOR of the data bits, before parity mode and flip
  int len; // Clocks per bit for this frame

  // Line idles high, like a pulled-up wire; one frame per go pulse
  initial
  begin
    line_o = 1'b1;
    busy_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i === 1'b1)
      begin
        busy_o <= 1'b1;
        len = short_i ? 2 : int'(bit_len_i);
        bits = {1'b0};
        // A short frame is a lone low pulse, too brief for a start bit
        if (!short_i)
        begin
          for (int i = 0; i < (len8_i ? 8 : 7); i++)
            bits.push_back(data_i[i]);
          par_b = ^(data_i & (len8_i ? 8'hFF : 8'h7F));
          // Parity generated the honest way, then optionally spoiled
          case (par_i)
            asr_pkg::PAR_EVEN: bits.push_back(par_b ^ par_flip_i);
            asr_pkg::PAR_ODD: bits.push_back(~par_b ^ par_flip_i);
            asr_pkg::PAR_ZERO: bits.push_back(par_flip_i);
            default: ;
          endcase
          bits.push_back(~stop_bad_i);
        end
        foreach (bits[i])
        begin
          line_o <= bits[i];
          repeat (len) @(posedge clk_i);
        end
        line_o <= 1'b1;
        busy_o <= 1'b0;
      end
    end
  end
endmodule : asr_tx_model
`default_nettype wire

/* File: dv/asr_receiver_bench.sv */
// Testbench: serial receiver against a behavioural reference
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module asr_receiver_bench;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk, rst_n, wr_s, rd_s; // Clock, reset, strobes
  logic [3:0] addr; // Register index
  logic [7:0] wdata, rdata; // Register data
  logic cmp_irq, err_irq; // Interrupt pulses
  logic tx_go, tx_short, tx_flip, tx_bad, tx_len8, tx_line, tx_busy;
  logic [7:0] tx_d; // Character handed to the sender
  logic [7:0] bit_len; // Clocks per bit at the sender
  asr_pkg::asr_par_e tx_par; // Sender parity mode
  asr_pkg::asr_mode_s md; // Mode as software last wrote it
  logic [31:0] rnd; // Random draw
  int seed = 3;
  int cyc, miscompares, checks_done, cmp_n, err_n, cmp_t, err_t;
  // Reference state kept by the bench
  logic [7:0] exp_buf;
  logic [2:0] exp_stat;
  logic unread;

  asr_receiver DUT (.CLK_I(clk), .RESETN_I(rst_n), .RXD_I(tx_line),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
    .RDATA_O(rdata), .CMP_IRQ_O(cmp_irq), .ERR_IRQ_O(err_irq));

  asr_tx_model tx (.clk_i(clk), .go_i(tx_go), .short_i(tx_short),
    .data_i(tx_d), .len8_i(tx_len8), .par_i(tx_par),
    .par_flip_i(tx_flip), .stop_bad_i(tx_bad), .bit_len_i(bit_len),
    .line_o(tx_line), .busy_o(tx_busy));

  // ==========================================================
  // Clock, interrupt monitor and hang guard
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulse counts and cycle stamps; a stuck run is cut at the ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cmp_irq === 1'b1)
    begin
      cmp_n++;
      cmp_t = cyc;
    end
    if (err_irq === 1'b1)
    begin
      err_n++;
      err_t = cyc;
    end
    if (cyc == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read data is looked at in the one cycle it stands
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
    @(posedge clk);
  endtask : rd_chk

  // Software order: status first, since the buffer read clears it
  task automatic sw_read();
    rd_chk(asr_pkg::ADDR_STAT, {5'h0, exp_stat});
    wr(asr_pkg::ADDR_RXBUF, 8'h5A);
    rd_chk(asr_pkg::ADDR_RXBUF, exp_buf);
    exp_stat = 3'h0;
    unread = 1'b0;
    rd_chk(asr_pkg::ADDR_STAT, 8'h00);
  endtask : sw_read

  // One frame from the sender, then the reference is brought along
  task automatic frame(input logic [7:0] d, input logic flip,
      input logic bad, input logic ab, input logic sh);
    logic [2:0] st;
    int e_c, e_e, g;
    cmp_n = 0;
    err_n = 0;
    tx_d <= d;
    tx_flip <= flip;
    tx_bad <= bad;
    tx_short <= sh;
    tx_len8 <= md.len8;
    tx_par <= md.parity;
    tx_go <= 1'b1;
    @(posedge clk);
    tx_go <= 1'b0;
    @(posedge clk);
    // Abort lands inside the character bits
    if (ab)
    begin
      repeat (24) @(posedge clk);
      md.rx_en = 1'b0;
      wr(asr_pkg::ADDR_MODE, md);
    end
    g = 0;
    while (tx_busy === 1'b1 && g < 1000)
    begin
      g++;
      @(posedge clk);
    end
    repeat (16) @(posedge clk);
    e_e = 0;
    e_c = 0;
    if (md.rx_en && !sh)
    begin
      st[2] = flip && (md.parity == asr_pkg::PAR_ODD ||
        md.parity == asr_pkg::PAR_EVEN);
      st[1] = bad;
      st[0] = unread;
      e_e = (st != 3'h0) ? 1 : 0;
      e_c = (!e_e || md.error_completion_irq_select) ? 1 : 0;
      exp_buf = md.len8 ? d : {1'b0, d[6:0]};
      exp_stat = st;
      unread = 1'b1;
    end
    `CHK(err_n, e_e)
    `CHK(cmp_n, e_c)
    if (e_e != 0 && e_c != 0)
      `CHK(cmp_t, err_t + 1)
  endtask : frame

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    {tx_go, tx_short, tx_flip, tx_bad, tx_len8} = 5'h00;
    tx_d = 8'h00;
    tx_par = asr_pkg::PAR_NONE;
    bit_len = 8'h08;
    md = asr_pkg::asr_mode_s'(asr_pkg::MODE_RST);
    exp_buf = asr_pkg::RXBUF_RST;
    exp_stat = asr_pkg::STAT_RST;
    unread = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped index, divisor
    rd_chk(asr_pkg::ADDR_MODE, asr_pkg::MODE_RST);
    rd_chk(asr_pkg::ADDR_BAUD, {3'h0, asr_pkg::BAUD_RST});
    rd_chk(asr_pkg::ADDR_RXBUF, asr_pkg::RXBUF_RST);
    rd_chk(asr_pkg::ADDR_STAT, {5'h0, asr_pkg::STAT_RST});
    wr(4'hC, 8'hFF);
    rd_chk(4'hC, 8'h00);
    wr(asr_pkg::ADDR_BAUD, 8'h08);
    rd_chk(asr_pkg::ADDR_BAUD, 8'h08);
    done("registers");
    rnd = $random(seed);
    frame(rnd[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
    done("disabled");
    // Every parity mode, length, error_completion_irq_select, with parity and stop faults
    for (int m = 0; m < 32; m++)
    begin
      md.rx_en = 1'b1;
      md.parity = asr_pkg::asr_par_e'(m[1:0]);
      md.len8 = m[2];
      md.stop2 = m[3];
      md.error_completion_irq_select = m[4];
      wr(asr_pkg::ADDR_MODE, md);
      rd_chk(asr_pkg::ADDR_MODE, md);
      rnd = $random(seed);
      frame(rnd[7:0], m[3], m[4] & m[0], 1'b0, 1'b0);
      sw_read();
    end
    done("formats");
    // Slower serial clocks: divide by 2, 4, 8; bit is 8 ticks of each
    for (int c = 1; c < 4; c++)
    begin
      md.clk_sel = c[1:0];
      wr(asr_pkg::ADDR_MODE, md);
      bit_len = 8'h08 << c;
      rnd = $random(seed);
      frame(rnd[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
      sw_read();
    end
    md.clk_sel = 2'h0;
    md.parity = asr_pkg::PAR_EVEN;
    wr(asr_pkg::ADDR_MODE, md);
    bit_len = 8'h08;
    done("divider");
    // Overrun: two frames, no read between
    rnd = $random(seed);
    frame(rnd[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
    frame(rnd[15:8], 1'b0, 1'b0, 1'b0, 1'b0);
    sw_read();
    done("overrun");
    // Abort after an errored frame leaves buffer and status alone
    frame(rnd[23:16], 1'b1, 1'b0, 1'b0, 1'b0);
    frame(rnd[31:24], 1'b0, 1'b0, 1'b1, 1'b0);
    md.rx_en = 1'b1;
    wr(asr_pkg::ADDR_MODE, md);
    sw_read();
    done("abort");
    // Short low pulse, then a good frame
    frame(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    rnd = $random(seed);
    frame(rnd[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
    sw_read();
    done("glitch");
    close_out();
  end
endmodule : asr_receiver_bench
`default_nettype wire
